// ==== src/hpw_map.vh ====
// Address map, field layout and constants of the page table walker
`ifndef HPW_MAP_VH
`define HPW_MAP_VH

// Register byte offsets, one aligned word each
`define HPW_OFF_BASE   12'h000
`define HPW_OFF_POS    12'h004
`define HPW_OFF_WID    12'h008
`define HPW_OFF_CTL    12'h00C
`define HPW_OFF_STAT   12'h010

// Reset value of every writable register
`define HPW_RST_WORD   32'h00000000

// Fields of walk_index_positions
`define HPW_F_GDI      4:0
`define HPW_F_UDI      9:5
`define HPW_F_MDI      14:10
`define HPW_F_PTI      19:15
`define HPW_F_ENTRY_SHIFT_AMOUNT     24:20

// Fields of walk_index_widths
`define HPW_F_GDW      4:0
`define HPW_F_UDW      9:5
`define HPW_F_MDW      14:10
`define HPW_F_PTW      19:15
`define HPW_F_ENTRY_SIZE_SELECT     21:20

// Fields of walk_control
`define HPW_F_EN       0
`define HPW_F_HUGE     1
`define HPW_F_PSN      6:2

// Fields of the status word
`define HPW_F_BUSY     0
`define HPW_F_STATE    3:1
`define HPW_F_LVL      5:4
`define HPW_F_RES      7:6

// Result codes of the last walk
`define HPW_RES_NONE   2'h0
`define HPW_RES_OK     2'h1
`define HPW_RES_REFILL 2'h2
`define HPW_RES_ASYNC  2'h3

// Pointer size is four bytes, a shift of two
`define HPW_PTR_SHIFT  3'h2
`define HPW_LVL_GLOBAL 2'h0
`define HPW_LVL_UPPER  2'h1
`define HPW_LVL_LEAF   2'h3
`define HPW_ONE_WORD   32'h00000001
`define HPW_ALL_ONES   32'hFFFFFFFF

`endif

// ==== src/hpw_walker.v ====
// Hardware page table walker with its APB configuration registers
`timescale 1ns/1ps
`include "hpw_map.vh"
module hpw_walker (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        refill_miss,
  input  wire [31:0] fault_addr,
  input  wire        access_uncached,
  input  wire        nonspec_range_hit,
  input  wire        error_level_flag,
  input  wire        exception_level_flag,
  input  wire        debug_mode_flag,
  input  wire        segment_config_present,
  input  wire        global_invalidate,
  input  wire        translation_op,
  input  wire        segment_control_write,
  input  wire        address_space_id_write,
  input  wire        memory_map_id_write,
  input  wire        async_event,
  output wire        mem_req,
  output reg  [31:0] mem_addr,
  output wire        mem_kernel,
  output wire        mem_use_segment_config,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  input  wire        mem_sync_fault,
  input  wire        mem_mapped_region,
  output reg         dup_invalidate,
  output reg         random_translation_write,
  output reg  [31:0] even_entry,
  output reg  [31:0] odd_entry,
  output reg         huge_entry,
  output reg         walk_done,
  output reg         refill_exception,
  output reg         async_abort
);

  localparam S_IDLE = 3'h0;
  localparam S_DIR  = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_HALF = 3'h3;
  localparam S_DUP  = 3'h4;
  localparam S_WR   = 3'h5;

  // One base per instance; each context instantiates its own walker
  reg  [31:0] walk_table_base;
  reg  [31:0] walk_index_positions;
  reg  [31:0] walk_index_widths;
  reg  [31:0] walk_control;
  reg  [2:0]  state;
  reg  [1:0]  lvl;
  reg         half;
  reg  [31:0] ptr;
  reg  [31:0] va;
  reg  [1:0]  last_result;
  reg  [4:0]  cur_w;
  reg  [4:0]  cur_l;

  wire [4:0]  global_dir_lsb;
  wire [4:0]  upper_dir_lsb;
  wire [4:0]  middle_dir_lsb;
  wire [4:0]  table_index_lsb;
  wire [4:0]  entry_shift_amount;
  wire [4:0]  global_dir_width;
  wire [4:0]  upper_dir_width;
  wire [4:0]  middle_dir_width;
  wire [4:0]  table_index_width;
  wire [1:0]  entry_size_select;
  wire [4:0]  flag_pos;
  wire        walker_enable_bit;
  wire        huge_support;

  assign global_dir_lsb     = walk_index_positions[`HPW_F_GDI];
  assign upper_dir_lsb      = walk_index_positions[`HPW_F_UDI];
  assign middle_dir_lsb     = walk_index_positions[`HPW_F_MDI];
  assign table_index_lsb    = walk_index_positions[`HPW_F_PTI];
  assign entry_shift_amount = walk_index_positions[`HPW_F_ENTRY_SHIFT_AMOUNT];
  assign global_dir_width   = walk_index_widths[`HPW_F_GDW];
  assign upper_dir_width    = walk_index_widths[`HPW_F_UDW];
  assign middle_dir_width   = walk_index_widths[`HPW_F_MDW];
  assign table_index_width  = walk_index_widths[`HPW_F_PTW];
  assign entry_size_select  = walk_index_widths[`HPW_F_ENTRY_SIZE_SELECT];
  assign flag_pos           = walk_control[`HPW_F_PSN];
  assign walker_enable_bit  = walk_control[`HPW_F_EN];
  assign huge_support       = walk_control[`HPW_F_HUGE];

  // APB decode; zero wait states, so the access phase always completes
  wire apb_access;
  wire apb_setup;
  wire addr_hit;
  wire apb_wr;
  wire cfg_write;

  assign apb_access = psel & penable;
  assign apb_setup  = psel & ~penable;
  assign addr_hit   = (paddr == `HPW_OFF_BASE) | (paddr == `HPW_OFF_POS) |
                      (paddr == `HPW_OFF_WID)  | (paddr == `HPW_OFF_CTL) |
                      (paddr == `HPW_OFF_STAT);
  assign apb_wr     = apb_access & pwrite & addr_hit;
  assign pready     = 1'b1;
  assign pslverr    = apb_access & ~addr_hit;
  // Any config register write counts, changed or not: simpler and never misses one
  assign cfg_write  = apb_wr & (paddr != `HPW_OFF_STAT);

  // Walker enable and start qualification
  wire any_dir;
  wire walk_enabled;
  wire cancel_any;
  wire can_start;
  wire busy;

  assign any_dir      = (global_dir_width != 5'h00) |
                        (upper_dir_width  != 5'h00) |
                        (middle_dir_width != 5'h00);
  assign walk_enabled = walker_enable_bit & any_dir &
                        ~(error_level_flag | exception_level_flag |
                          debug_mode_flag);
  // Cancel sources act in any cycle they are high; cfg_write only in the APB access phase
  assign cancel_any   = global_invalidate | translation_op | cfg_write |
                        segment_control_write | address_space_id_write |
                        memory_map_id_write;
  assign can_start    = walk_enabled & ~access_uncached &
                        ~nonspec_range_hit & ~cancel_any;
  assign busy         = (state != S_IDLE);

  // Loads are kernel privilege; segment source passed to load path
  assign mem_kernel             = 1'b1;
  assign mem_use_segment_config = segment_config_present;
  // Request held only while waiting: one read in flight at a time
  assign mem_req                = (state == S_WAIT);

  // Width and position of the directory level being walked
  always @*
  begin
    case (lvl)
      `HPW_LVL_GLOBAL:
      begin
        cur_w = global_dir_width;
        cur_l = global_dir_lsb;
      end
      `HPW_LVL_UPPER:
      begin
        cur_w = upper_dir_width;
        cur_l = upper_dir_lsb;
      end
      default:
      begin
        cur_w = middle_dir_width;
        cur_l = middle_dir_lsb;
      end
    endcase
  end

  // Address generation for directory, leaf and second half
  wire [31:0] dir_idx;
  wire [31:0] dir_addr;
  wire [31:0] pt_idx;
  wire [31:0] leaf_addr;
  wire [31:0] half2_addr;
  wire [31:0] entry_shifted;
  wire [2:0]  leaf_shift;
  wire        entry_is_leaf_flag;

  assign dir_idx    = (va >> cur_l) & ~(`HPW_ALL_ONES << cur_w);
  assign dir_addr   = ptr | (dir_idx << `HPW_PTR_SHIFT);
  assign pt_idx     = (va >> table_index_lsb) &
                      ~(`HPW_ALL_ONES << table_index_width);
  assign leaf_shift = `HPW_PTR_SHIFT + {1'b0, entry_size_select};
  assign leaf_addr  = ptr | (pt_idx << leaf_shift);
  assign half2_addr = ptr | (`HPW_ONE_WORD << entry_shift_amount);
  assign entry_shifted      = mem_rdata >> entry_shift_amount;
  assign entry_is_leaf_flag = mem_rdata[flag_pos];

  // Walk sequencer; cancel beats asynchronous beats synchronous
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                    <= S_IDLE;
      lvl                      <= `HPW_LVL_GLOBAL;
      half                     <= 1'b0;
      ptr                      <= `HPW_RST_WORD;
      va                       <= `HPW_RST_WORD;
      mem_addr                 <= `HPW_RST_WORD;
      even_entry               <= `HPW_RST_WORD;
      odd_entry                <= `HPW_RST_WORD;
      huge_entry               <= 1'b0;
      dup_invalidate           <= 1'b0;
      random_translation_write <= 1'b0;
      walk_done                <= 1'b0;
      refill_exception         <= 1'b0;
      async_abort              <= 1'b0;
      last_result              <= `HPW_RES_NONE;
    end
    else
    begin
      dup_invalidate           <= 1'b0;
      random_translation_write <= 1'b0;
      walk_done                <= 1'b0;
      refill_exception         <= 1'b0;
      async_abort              <= 1'b0;
      if (busy & cancel_any)
      begin
        // Pending buffer write dropped with the walk
        state       <= S_IDLE;
        last_result <= `HPW_RES_NONE;
      end
      else if (busy & async_event)
      begin
        state       <= S_IDLE;
        async_abort <= 1'b1;
        last_result <= `HPW_RES_ASYNC;
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            if (refill_miss & can_start)
            begin
              va    <= fault_addr;
              ptr   <= walk_table_base;
              lvl   <= `HPW_LVL_GLOBAL;
              half  <= 1'b0;
              state <= S_DIR;
            end
            else if (refill_miss)
            begin
              // Declined miss goes to the software refill handler
              refill_exception <= 1'b1;
              last_result      <= `HPW_RES_REFILL;
            end
          end
          S_DIR:
          begin
            if (lvl == `HPW_LVL_LEAF)
            begin
              mem_addr <= leaf_addr;
              ptr      <= leaf_addr;
              half     <= 1'b0;
              state    <= S_WAIT;
            end
            else if (cur_w == 5'h00)
            begin
              lvl <= lvl + 2'h1;
            end
            else
            begin
              mem_addr <= dir_addr;
              state    <= S_WAIT;
            end
          end
          S_WAIT:
          begin
            if (mem_ack & (mem_sync_fault | mem_mapped_region))
            begin
              // Abort to the refill handler; no support for mapped-region reads
              state            <= S_IDLE;
              refill_exception <= 1'b1;
              last_result      <= `HPW_RES_REFILL;
            end
            else if (mem_ack & (lvl != `HPW_LVL_LEAF))
            begin
              if (huge_support & entry_is_leaf_flag)
              begin
                even_entry <= entry_shifted;
                odd_entry  <= entry_shifted;
                huge_entry <= 1'b1;
                state      <= S_DUP;
              end
              else
              begin
                ptr   <= mem_rdata;
                lvl   <= lvl + 2'h1;
                state <= S_DIR;
              end
            end
            else if (mem_ack & ~half)
            begin
              // Leaf level: flag bit is not looked at
              even_entry <= entry_shifted;
              half       <= 1'b1;
              state      <= S_HALF;
            end
            else if (mem_ack)
            begin
              odd_entry  <= entry_shifted;
              huge_entry <= 1'b0;
              state      <= S_DUP;
            end
          end
          S_HALF:
          begin
            // Request drops a cycle between the two halves
            mem_addr <= half2_addr;
            state    <= S_WAIT;
          end
          S_DUP:
          begin
            dup_invalidate <= 1'b1;
            state          <= S_WR;
          end
          S_WR:
          begin
            // Only the buffer is written, never the software registers
            random_translation_write <= 1'b1;
            walk_done                <= 1'b1;
            last_result              <= `HPW_RES_OK;
            state                    <= S_IDLE;
          end
          default:
          begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Configuration registers, written at the APB access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      walk_table_base      <= `HPW_RST_WORD;
      walk_index_positions <= `HPW_RST_WORD;
      walk_index_widths    <= `HPW_RST_WORD;
      walk_control         <= `HPW_RST_WORD;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `HPW_OFF_BASE: walk_table_base      <= pwdata;
        `HPW_OFF_POS:  walk_index_positions <= pwdata;
        `HPW_OFF_WID:  walk_index_widths    <= pwdata;
        `HPW_OFF_CTL:  walk_control         <= pwdata;
        default:       walk_control         <= walk_control;
      endcase
    end
  end

  // Status word showing the walker's own state
  reg [31:0] status_word;

  always @*
  begin
    status_word                = `HPW_RST_WORD;
    status_word[`HPW_F_BUSY]   = busy;
    status_word[`HPW_F_STATE]  = state;
    status_word[`HPW_F_LVL]    = lvl;
    status_word[`HPW_F_RES]    = last_result;
  end

  // Read data captured in setup so it comes from a flip-flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `HPW_RST_WORD;
    end
    else if (apb_setup & ~pwrite)
    begin
      case (paddr)
        `HPW_OFF_BASE: prdata <= walk_table_base;
        `HPW_OFF_POS:  prdata <= walk_index_positions;
        `HPW_OFF_WID:  prdata <= walk_index_widths;
        `HPW_OFF_CTL:  prdata <= walk_control;
        `HPW_OFF_STAT: prdata <= status_word;
        default:       prdata <= `HPW_RST_WORD;
      endcase
    end
  end

endmodule // hpw_walker

// ==== verification/hpw_mem_model.sv ====
// Load path model answering the walker's memory reads
`timescale 1ns/1ps
module hpw_mem_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         mem_req,
  input  wire  [31:0] mem_addr,
  input  wire  [3:0]  delay,
  input  wire  [1:0]  fault,
  output logic        mem_ack,
  output logic [31:0] mem_rdata,
  output logic        mem_sync_fault,
  output logic        mem_mapped_region
);
  logic [3:0]  wait_cnt;
  logic [31:0] last_word;
  // Age of the outstanding read; a withdrawn read starts over
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt  <= 4'h0;
      last_word <= 32'h00000000;
    end
    else if (mem_req && !mem_ack)
      wait_cnt <= wait_cnt + 4'h1;
    else
    begin
      wait_cnt  <= 4'h0;
      last_word <= mem_ack ? mem_rdata : last_word;
    end
  end
  // One answer per read, given only while the request stands
  assign mem_ack = mem_req && (wait_cnt == delay);
  // Between answers the lines carry stale inverted data, never a match
  assign mem_rdata = mem_ack ? {mem_addr[15:0], 16'h0000} : ~last_word;
  assign mem_sync_fault = mem_ack ? (fault == 2'h1) : ~last_word[0];
  assign mem_mapped_region = mem_ack ? (fault == 2'h2) : last_word[0];
endmodule // hpw_mem_model

// ==== verification/hpw_walker_assertions.sv ====
// Port-level checker for the page table walker
`timescale 1ns/1ps
module hpw_walker_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        refill_miss,
  input wire        access_uncached,
  input wire        nonspec_range_hit,
  input wire        error_level_flag,
  input wire        exception_level_flag,
  input wire        debug_mode_flag,
  input wire        segment_config_present,
  input wire        global_invalidate,
  input wire        translation_op,
  input wire        segment_control_write,
  input wire        address_space_id_write,
  input wire        memory_map_id_write,
  input wire        async_event,
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire        mem_kernel,
  input wire        mem_use_segment_config,
  input wire        mem_ack,
  input wire        mem_sync_fault,
  input wire        mem_mapped_region,
  input wire        dup_invalidate,
  input wire        random_translation_write,
  input wire        walk_done,
  input wire        refill_exception,
  input wire        async_abort
);
  logic cancel_any;
  logic quiet;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Every cancel source, config register writes included
  assign cancel_any = global_invalidate | translation_op |
    segment_control_write | address_space_id_write | memory_map_id_write |
    (psel & penable & pwrite & (paddr < 12'h010));
  // Idle tracker; a miss in the same cycle as an ending pulse leaves it set though a walk may start
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet <= 1'b1;
    else if (walk_done | refill_exception | async_abort | cancel_any)
      quiet <= 1'b1;
    else if (refill_miss)
      quiet <= 1'b0;
  end
  sequence s_declined;
    refill_exception ##1 !mem_req [*2];
  endsequence
  sequence s_commit;
    random_translation_write && walk_done;
  endsequence
  a_declined_miss:
  assert property (quiet && refill_miss && !cancel_any && (access_uncached
    | nonspec_range_hit | error_level_flag | exception_level_flag
    | debug_mode_flag) |=> s_declined) else $error("declined miss walked");
  a_cancel_stops:
  assert property (cancel_any |=> !mem_req && !walk_done
    && !random_translation_write) else $error("cancel did not stop walk");
  a_kernel_load:
  assert property (mem_req |-> mem_kernel) else $error("read not kernel");
  a_segment_source:
  assert property (mem_use_segment_config == segment_config_present)
    else $error("segment source wrong");
  a_dup_first:
  assert property (dup_invalidate && !cancel_any && !async_event
    |=> s_commit)
    else $error("write did not follow invalidate");
  a_sync_abort:
  assert property (mem_ack && (mem_sync_fault || mem_mapped_region)
    && !async_event && !cancel_any |=> refill_exception && !walk_done
    && !dup_invalidate) else $error("faulted read not aborted");
  a_async_abort:
  assert property (mem_req && async_event && !cancel_any |=> async_abort
    && !refill_exception) else $error("async event not taken");
  a_addr_steady:
  assert property (mem_req && !mem_ack ##1 mem_req |-> $stable(mem_addr))
    else $error("read address moved");
endmodule // hpw_walker_checker

bind hpw_walker hpw_walker_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .refill_miss,
  .access_uncached, .nonspec_range_hit, .error_level_flag,
  .exception_level_flag, .debug_mode_flag, .segment_config_present,
  .global_invalidate, .translation_op, .segment_control_write,
  .address_space_id_write, .memory_map_id_write, .async_event, .mem_req,
  .mem_addr, .mem_kernel, .mem_use_segment_config, .mem_ack,
  .mem_sync_fault, .mem_mapped_region, .dup_invalidate,
  .random_translation_write, .walk_done, .refill_exception, .async_abort);

// ==== verification/tb_top.sv ====
// Self-checking bench for the page table walker
`timescale 1ns/1ps
`include "hpw_map.vh"
module tb_top;
  localparam [31:0] BASE = 32'h00400000;
  localparam [31:0] FA   = 32'h12345000;
  localparam [31:0] WG   = 32'h0015000A;
  logic        pclk, presetn = 1'b0, pready, pslverr, mem_req, mem_ack;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, async_event = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, fault_addr = 32'h00000000;
  logic [31:0] prdata, mem_addr, mem_rdata, even_entry, odd_entry;
  logic        refill_miss = 1'b0, access_uncached = 1'b0;
  logic        nonspec_range_hit = 1'b0, error_level_flag = 1'b0;
  logic        exception_level_flag = 1'b0, debug_mode_flag = 1'b0;
  logic        segment_config_present = 1'b0, mem_kernel, huge_entry;
  logic        mem_use_segment_config, mem_sync_fault, mem_mapped_region;
  logic        dup_invalidate, random_translation_write;
  logic        walk_done, refill_exception, async_abort;
  logic [4:0]  cxl = 5'h00;
  logic [3:0]  mem_delay = 4'h0;
  logic [1:0]  mem_fault = 2'h0;
  int          error_cnt, cmp_count, n_done, n_refill, n_async, n_dup;

  hpw_walker u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .refill_miss, .fault_addr, .access_uncached,
    .nonspec_range_hit, .error_level_flag, .exception_level_flag,
    .debug_mode_flag, .segment_config_present, .global_invalidate(cxl[0]),
    .translation_op(cxl[1]), .segment_control_write(cxl[2]),
    .address_space_id_write(cxl[3]), .memory_map_id_write(cxl[4]),
    .async_event, .mem_req, .mem_addr, .mem_kernel, .mem_use_segment_config,
    .mem_ack, .mem_rdata, .mem_sync_fault, .mem_mapped_region,
    .dup_invalidate, .random_translation_write, .even_entry, .odd_entry,
    .huge_entry, .walk_done, .refill_exception, .async_abort);
  hpw_mem_model u_mem (
    .pclk, .presetn, .mem_req, .mem_addr, .delay(mem_delay),
    .fault(mem_fault), .mem_ack, .mem_rdata, .mem_sync_fault,
    .mem_mapped_region);

  // 25 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Tally of the walker's ending pulses and of its invalidate pulses
  always @(posedge pclk)
  begin
    if (walk_done === 1'b1) n_done++;
    if (refill_exception === 1'b1) n_refill++;
    if (async_abort === 1'b1) n_async++;
    if (dup_invalidate === 1'b1) n_dup++;
  end

  function automatic [31:0] word(input [31:0] a);
    return {a[15:0], 16'h0000};
  endfunction
  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // APB transfer, entered just after a rising edge
  task automatic apb(input bit w, input [11:0] a, input [31:0] d,
                     output [31:0] rd, output err);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic miss();
    fault_addr  <= FA;
    refill_miss <= 1'b1;
    @(posedge pclk);
    refill_miss <= 1'b0;
  endtask
  // Bounded wait for any ending pulse
  task automatic wait_end(input int n0);
    for (int i = 0; i < 300 && n_done + n_refill + n_async == n0; i++)
      @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, `HPW_OFF_CTL, 32'h00000000, r, e);
    chk("control reset", `HPW_RST_WORD, r);
    wr(`HPW_OFF_BASE, BASE);
    wr(`HPW_OFF_POS, 32'h00265816);
    wr(`HPW_OFF_CTL, 32'h00000001);
    apb(1'b0, `HPW_OFF_POS, 32'h00000000, r, e);
    chk("positions", 32'h00265816, r);
    apb(1'b0, 12'h020, 32'h00000000, r, e);
    chk("unmapped error", 32'h00000001, {31'h0, e});
  endtask
  // Full walk; leaf halves depend on every address the walker formed
  task automatic t_walk(input [31:0] wid, input [3:0] dly);
    logic [31:0] ea;
    int n0;
    ea = word(BASE | (((FA >> 22) & 32'h000003FF) << 2));
    ea = ea | (((FA >> 12) & 32'h000003FF) << 3);
    wr(`HPW_OFF_WID, wid);
    mem_delay <= dly;
    n0 = n_done;
    miss();
    wait_end(n0 + n_refill + n_async);
    chk("walks done", n0 + 1, n_done);
    chk("even half", word(ea) >> 2, even_entry);
    chk("odd half", word(ea | 32'h00000004) >> 2, odd_entry);
    chk("not huge", 32'h0, {31'h0, huge_entry});
    chk("invalidates", n_done, n_dup);
  endtask
  // Huge page at the global level: flag at bit 21 of the fetched entry
  task automatic t_huge();
    int n0;
    wr(`HPW_OFF_CTL, 32'h00000057);
    n0 = n_done;
    miss();
    wait_end(n0 + n_refill + n_async);
    chk("huge done", n0 + 1, n_done);
    chk("huge flag", 32'h1, {31'h0, huge_entry});
    chk("huge even", word(BASE | ((FA >> 22) << 2)) >> 2, even_entry);
    chk("huge odd", word(BASE | ((FA >> 22) << 2)) >> 2, odd_entry);
    // Flag moved to bit 0, which directory pointers leave clear
    wr(`HPW_OFF_CTL, 32'h00000003);
  endtask
  // Each condition that withholds a walk, apart from a held cancel source
  task automatic t_declined();
    int n0;
    for (int k = 0; k < 7; k++)
    begin
      n0 = n_refill;
      access_uncached      <= (k == 0);
      nonspec_range_hit    <= (k == 1);
      error_level_flag     <= (k == 2);
      exception_level_flag <= (k == 3);
      debug_mode_flag      <= (k == 4);
      if (k >= 5)
        wr(`HPW_OFF_CTL, {31'h0, k == 6});
      if (k == 6)
        wr(`HPW_OFF_WID, 32'h00150000);
      miss();
      repeat (3) @(posedge pclk);
      chk("declined miss", n0 + 1, n_refill);
    end
    wr(`HPW_OFF_WID, WG);
  endtask
  // Faulting read, then an asynchronous event mid-walk
  task automatic t_aborts();
    int n0;
    for (int f = 1; f < 3; f++)
    begin
      mem_fault <= f[1:0];
      n0 = n_refill;
      miss();
      wait_end(n0 + n_done + n_async);
      chk("fault refill", n0 + 1, n_refill);
    end
    mem_fault <= 2'h0;
    mem_delay <= 4'h6;
    n0 = n_async;
    miss();
    repeat (3) @(posedge pclk);
    async_event <= 1'b1;
    @(posedge pclk);
    async_event <= 1'b0;
    wait_end(n0 + n_done + n_refill);
    chk("async abort", n0 + 1, n_async);
  endtask
  // Every cancel source in mid-walk, a blocked miss while it is held
  task automatic t_cancel();
    int n0;
    for (int k = 0; k < 6; k++)
    begin
      n0 = n_done + n_async;
      miss();
      repeat (3) @(posedge pclk);
      // The register write cancels only at its access edge, so the
      // blocked miss is lined up with that edge
      if (k == 5)
        fork
          wr(`HPW_OFF_BASE, BASE);
          begin
            @(posedge pclk);
            miss();
          end
        join
      else
      begin
        cxl <= 5'h01 << k;
        miss();
      end
      cxl <= 5'h00;
      repeat (20) @(posedge pclk);
      chk("cancelled walk", n0, n_done + n_async);
      chk("read after cancel", 32'h0, {31'h0, mem_req});
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_walk(WG, 4'h0);
    segment_config_present <= 1'b1;
    t_walk(32'h00152800, 4'h3);
    t_declined();
    t_aborts();
    t_cancel();
    t_huge();
    t_walk(WG, 4'h1);
    wrap_up();
  end
  // Watchdog at 10000 cycles, far beyond the few hundred the tests need
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb_top
